// ---- shared/tph_pkg.sv ----
// tph_pkg: shared constants and types for the parallel host port block
// assumes a single reference clock domain plus a host-supplied transmit link clock
package tph_pkg;

    // ------------------------------------------------------------
    // three-level static input encoding
    // ------------------------------------------------------------
    // each three-level pin arrives as two sense bits {high_sense, low_sense}
    localparam logic [1:0] TRI_PIN_LOW  = 2'h0;   // tied to ground
    localparam logic [1:0] TRI_PIN_HIGH = 2'h3;   // tied to supply
    // any other pattern means the pin self-biased to its middle level

    typedef enum logic [1:0]
    {
        TPH_LVL_LOW  = 2'b00,
        TPH_LVL_MID  = 2'b01,
        TPH_LVL_HIGH = 2'b10
    } tph_level_e;

    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int TX_DATA_W    = 8;              // transmit data bits
    localparam int TX_CTRL_W    = 2;              // transmit control bits
    localparam int TX_WORD_W    = TX_DATA_W + TX_CTRL_W;
    localparam int RX_RAW_W     = 10;             // raw undecoded character
    localparam int RX_BYTE_W    = 8;              // parallel receive byte
    localparam int RX_STAT_W    = 3;              // receive status bits
    localparam int TX_MODE_CNT  = 9;              // transmit path modes
    localparam int LEVELS       = 3;              // values of a three-level pin
    localparam int PHASE_W      = 4;              // phase tracking counter width
    localparam int CFG_W        = 10;             // bundled static pins

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [TX_WORD_W-1:0]   TX_WORD_RST = 10'h000;
    localparam logic [TX_MODE_CNT-1:0] TX_MODE_RST = 9'h001;
    localparam logic [PHASE_W-1:0]     PHASE_RST   = 4'h0;
    localparam logic [RX_BYTE_W-1:0]   RX_BYTE_RST = 8'h00;
    localparam logic [RX_STAT_W-1:0]   RX_STAT_RST = 3'h0;
    localparam logic [CFG_W-1:0]       CFG_RST     = 10'h000;

endpackage : tph_pkg

// ---- logic/tph_host_port.sv ----
// tph_host_port: parallel host port of a serial transceiver (transmit input
// register, transmit clock phase tracking, mode decode, receive output register)
// assumes tx data pins and receive decoder inputs are synchronous to clock;
// tx_input_clock is the host's transmit clock, unrelated in phase to clock
`timescale 1ns/1ps

// Summary of operation
// R01 - Host must not pick host transmit clock while half-rate reference is selected.
// R02 - Host transmit clock matches synthesized transmit clock frequency; phase offset allowed.
// R03 - Track transmit clock phase while align reset low; freeze it when high.
// R04 - Two three-level mode pins decode to exactly one of nine modes.
// R05 - Half-rate reference: sample inputs on both rising and falling edges.
// R06 - Three-level pins resolve low, middle or high; floating reads middle.
// R07 - Receive byte outputs update only after the selected receive clock rising edge.
// R08 - Decoder enabled: outputs carry decoded byte or special, status tells which.
// R09 - Decoder bypassed: outputs carry upper eight bits of raw ten-bit character.
// R10 - Bypass: low status bits are raw low bits, top bit flags comma.
// R11 - Select low: reference clock loads transmit register; else host transmit clock.
module tph_host_port
(
    // clock and reset
    input  wire logic                           clock,
    input  wire logic                           resetn,
    // host transmit link
    input  wire logic                           tx_input_clock,
    input  wire logic [tph_pkg::TX_DATA_W-1:0]  tx_data,
    input  wire logic [tph_pkg::TX_CTRL_W-1:0]  tx_ctrl,
    // static configuration pins (three-level ones as sense pairs)
    input  wire logic [1:0]                     tx_input_clock_select,
    input  wire logic [3:0]                     tx_operating_mode_select,
    input  wire logic [1:0]                     decoder_mode_select,
    input  wire logic                           tx_ref_rate_select,
    input  wire logic                           tx_phase_align_reset,
    // receive characters from the decoder
    input  wire logic [tph_pkg::RX_RAW_W-1:0]   rx_raw_char,
    input  wire logic [tph_pkg::RX_BYTE_W-1:0]  rx_dec_byte,
    input  wire logic [tph_pkg::RX_STAT_W-1:0]  rx_dec_status,
    input  wire logic                           rx_comma_det,
    input  wire logic                           rx_char_valid,
    // transmit characters toward the encoder
    output logic      [tph_pkg::TX_WORD_W-1:0]  tx_word,
    output logic      [tph_pkg::TX_WORD_W-1:0]  tx_word_second,
    output logic                                tx_word_valid,
    output logic                                tx_word_pair,
    output logic      [tph_pkg::PHASE_W-1:0]    tx_phase_offset,
    output logic      [tph_pkg::TX_MODE_CNT-1:0] tx_mode_onehot,
    output logic                                tx_config_invalid,
    // receive characters toward the host
    output logic      [tph_pkg::RX_BYTE_W-1:0]  rx_byte,
    output logic      [tph_pkg::RX_STAT_W-1:0]  rx_char_status,
    output logic                                rx_char_clock_out
);

    // ------------------------------------------------------------
    // three-level pin resolution
    // ------------------------------------------------------------
    // anything neither hard low nor hard high is the middle level
    function automatic tph_pkg::tph_level_e tri_level(input logic [1:0] pin);
        if (pin == tph_pkg::TRI_PIN_LOW)
            return tph_pkg::TPH_LVL_LOW;
        else if (pin == tph_pkg::TRI_PIN_HIGH)
            return tph_pkg::TPH_LVL_HIGH;
        else
            return tph_pkg::TPH_LVL_MID;
    endfunction : tri_level

    // ------------------------------------------------------------
    // link domain: host-clocked transmit capture
    // ------------------------------------------------------------
    logic [tph_pkg::TX_WORD_W-1:0] link_hold_r;
    logic                          link_tog_r;
    // word held a full link period; toggle marks each new word
    always_ff @(posedge tx_input_clock or negedge resetn)
    begin
        if (!resetn)
        begin
            link_hold_r <= tph_pkg::TX_WORD_RST;
            link_tog_r  <= 1'b0;
        end
        else
        begin
            link_hold_r <= {tx_ctrl, tx_data};  // R11
            link_tog_r  <= ~link_tog_r;
        end
    end

    // ------------------------------------------------------------
    // synchronisers into the clock domain
    // ------------------------------------------------------------
    logic [tph_pkg::CFG_W-1:0] cfg_s1_r;
    logic [tph_pkg::CFG_W-1:0] cfg_s2_r;
    logic                      tog_s1_r;
    logic                      tog_s2_r;
    logic                      tog_s3_r;
    // two flops for static pins, three for the word toggle
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_s1_r <= tph_pkg::CFG_RST;
            cfg_s2_r <= tph_pkg::CFG_RST;
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
        end
        else
        begin
            cfg_s1_r <= {tx_input_clock_select, tx_operating_mode_select,
                         decoder_mode_select, tx_ref_rate_select, tx_phase_align_reset};
            cfg_s2_r <= cfg_s1_r;
            tog_s1_r <= link_tog_r;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
        end
    end

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    tph_pkg::tph_level_e sel_lvl;
    tph_pkg::tph_level_e mode_hi_lvl;
    tph_pkg::tph_level_e mode_lo_lvl;
    tph_pkg::tph_level_e dec_lvl;
    logic                rate_half;
    logic                align_rst;
    logic                sel_link;
    logic                dec_bypass;
    logic                link_event;
    logic [3:0]          mode_idx;
    assign sel_lvl     = tri_level(cfg_s2_r[9:8]);                          // R06
    assign mode_hi_lvl = tri_level(cfg_s2_r[7:6]);                          // R06
    assign mode_lo_lvl = tri_level(cfg_s2_r[5:4]);                          // R06
    assign dec_lvl     = tri_level(cfg_s2_r[3:2]);                          // R06
    assign rate_half   = cfg_s2_r[1];
    assign align_rst   = cfg_s2_r[0];
    assign sel_link    = (sel_lvl != tph_pkg::TPH_LVL_LOW);                // R11
    assign dec_bypass  = (dec_lvl == tph_pkg::TPH_LVL_LOW);
    assign link_event  = tog_s2_r ^ tog_s3_r;
    assign mode_idx    = 4'(mode_hi_lvl) * 4'(tph_pkg::LEVELS) + 4'(mode_lo_lvl); // R04

    // ------------------------------------------------------------
    // transmit input register and mode
    // ------------------------------------------------------------
    logic [tph_pkg::TX_WORD_W-1:0]   neg_word_r;
    logic [tph_pkg::TX_WORD_W-1:0]   tx_word_r;
    logic [tph_pkg::TX_WORD_W-1:0]   tx_word_nxt;
    logic [tph_pkg::TX_WORD_W-1:0]   tx_second_r;
    logic                            tx_valid_r;
    logic                            tx_valid_nxt;
    logic                            tx_pair_r;
    logic                            tx_pair_nxt;
    logic [tph_pkg::TX_MODE_CNT-1:0] tx_mode_r;
    logic [tph_pkg::TX_MODE_CNT-1:0] tx_mode_nxt;
    logic                            cfg_bad_r;
    // falling-edge capture for the half-rate reference
    always_ff @(negedge clock or negedge resetn)
    begin
        if (!resetn)
            neg_word_r <= tph_pkg::TX_WORD_RST;
        else
            neg_word_r <= {tx_ctrl, tx_data};   // R05
    end

    // source select: host clock word on its arrival, else every reference edge
    assign tx_word_nxt  = sel_link ? (link_event ? link_hold_r : tx_word_r) : {tx_ctrl, tx_data};
    assign tx_valid_nxt = sel_link ? link_event : 1'b1;                     // R11
    assign tx_pair_nxt  = !sel_link && rate_half;                           // R05
    assign tx_mode_nxt  = (tph_pkg::TX_MODE_CNT)'(1) << mode_idx;          // R04

    // transmit registers
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_word_r   <= tph_pkg::TX_WORD_RST;
            tx_second_r <= tph_pkg::TX_WORD_RST;
            tx_valid_r  <= 1'b0;
            tx_pair_r   <= 1'b0;
            tx_mode_r   <= tph_pkg::TX_MODE_RST;
            cfg_bad_r   <= 1'b0;
        end
        else
        begin
            tx_word_r   <= tx_word_nxt;
            tx_second_r <= neg_word_r;          // R05
            tx_valid_r  <= tx_valid_nxt;
            tx_pair_r   <= tx_pair_nxt;
            tx_mode_r   <= tx_mode_nxt;         // R04
            cfg_bad_r   <= rate_half && sel_link;   // R01
        end
    end

    // ------------------------------------------------------------
    // transmit clock phase tracking
    // ------------------------------------------------------------
    logic [tph_pkg::PHASE_W-1:0] phase_cnt_r;
    logic [tph_pkg::PHASE_W-1:0] tx_phase_r;
    logic [tph_pkg::PHASE_W-1:0] tx_phase_nxt;
    // sample free-running count at each host word while tracking
    assign tx_phase_nxt = (!align_rst && link_event) ? phase_cnt_r : tx_phase_r; // R03

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            phase_cnt_r <= tph_pkg::PHASE_RST;
            tx_phase_r  <= tph_pkg::PHASE_RST;
        end
        else
        begin
            phase_cnt_r <= phase_cnt_r + 1'b1;
            tx_phase_r  <= tx_phase_nxt;        // R03
        end
    end

    // ------------------------------------------------------------
    // receive output register
    // ------------------------------------------------------------
    logic [tph_pkg::RX_BYTE_W-1:0] rx_byte_r;
    logic [tph_pkg::RX_BYTE_W-1:0] rx_byte_nxt;
    logic [tph_pkg::RX_STAT_W-1:0] rx_stat_r;
    logic [tph_pkg::RX_STAT_W-1:0] rx_stat_nxt;
    logic                          rx_clk_r;
    // bypass exposes the raw character, else the decoded one
    assign rx_byte_nxt = dec_bypass ? rx_raw_char[9:2] : rx_dec_byte;           // R08 R09
    assign rx_stat_nxt = dec_bypass ? {rx_comma_det, rx_raw_char[1:0]} : rx_dec_status; // R10

    // data and character clock rise on the same edge
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_byte_r <= tph_pkg::RX_BYTE_RST;
            rx_stat_r <= tph_pkg::RX_STAT_RST;
            rx_clk_r  <= 1'b0;
        end
        else
        begin
            if (rx_char_valid)
            begin
                rx_byte_r <= rx_byte_nxt;       // R07
                rx_stat_r <= rx_stat_nxt;       // R07
            end
            rx_clk_r <= rx_char_valid;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign tx_word           = tx_word_r;
    assign tx_word_second    = tx_second_r;
    assign tx_word_valid     = tx_valid_r;
    assign tx_word_pair      = tx_pair_r;
    assign tx_phase_offset   = tx_phase_r;
    assign tx_mode_onehot    = tx_mode_r;
    assign tx_config_invalid = cfg_bad_r;
    assign rx_byte           = rx_byte_r;
    assign rx_char_status    = rx_stat_r;
    assign rx_char_clock_out = rx_clk_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    mode_onehot_a: assert property ($onehot(tx_mode_r)) // R04
        else $error("transmit mode not one-hot");
    mode_map_a: assert property (##1 tx_mode_r == 9'h001 << $past(mode_idx)) // R04
        else $error("transmit mode does not follow mode pins");
    float_mid_a: assert property (cfg_s2_r[9:8] == 2'h1 |=> tx_valid_r == $past(link_event)) // R06
        else $error("floating select not read as middle");
    ref_path_a: assert property (!sel_link |=> // R11
        tx_valid_r && tx_word_r == $past({tx_ctrl, tx_data}))
        else $error("reference path word not taken");
    half_pair_a: assert property (rate_half && !sel_link |=> // R05
        tx_pair_r ##1 tx_word_second == $past(neg_word_r))
        else $error("half-rate second word missing");
    bad_cfg_a: assert property (rate_half && sel_link |=> tx_config_invalid) // R01
        else $error("invalid clock combination not flagged");
    phase_track_a: assert property (!align_rst && link_event |=> // R03
        tx_phase_r == $past(phase_cnt_r))
        else $error("phase not tracked");
    phase_freeze_a: assert property (align_rst [*2] |=> $stable(tx_phase_r)) // R03
        else $error("phase moved while frozen");
    rx_hold_a: assert property (!rx_char_valid |=> $stable(rx_byte_r) && $stable(rx_stat_r)) // R07
        else $error("receive byte changed without a character");
    rx_bypass_a: assert property (rx_char_valid && dec_bypass |=> // R09 R10
        rx_byte_r == $past(rx_raw_char[9:2]) &&
        rx_stat_r == $past({rx_comma_det, rx_raw_char[1:0]}))
        else $error("bypass byte mapping wrong");
    rx_decoded_a: assert property (rx_char_valid && !dec_bypass |=> // R08
        rx_byte_r == $past(rx_dec_byte) && rx_stat_r == $past(rx_dec_status))
        else $error("decoded byte mapping wrong");
    link_word_c: cover property (sel_link && link_event ##1 tx_valid_r);
    half_rate_c: cover property (rate_half && !sel_link ##1 tx_pair_r);
    bypass_c:    cover property (rx_char_valid && dec_bypass && rx_comma_det);
    freeze_c:    cover property (!align_rst ##1 align_rst [*3]);
endmodule : tph_host_port

// ---- bench/tph_host_model.sv ----
// tph_host_model: host logic that feeds transmit characters to the port
// assumes link_sel follows the transmit input clock select pins
`timescale 1ns/1ps

module tph_host_model
(
    // reference side
    input  wire logic                          clock,
    input  wire logic                          link_sel,
    input  wire logic                          half_rate,
    // host transmit link
    output logic                               tx_input_clock,
    output logic [tph_pkg::TX_DATA_W-1:0]      tx_data,
    output logic [tph_pkg::TX_CTRL_W-1:0]      tx_ctrl
);
    int   seed   = 60591;
    logic hold_r = 1'b0;

    // link clock: rests low while not selected, fixed rate when running
    initial
    begin
        tx_input_clock = 1'b0;
        {tx_ctrl, tx_data} = 10'h000;
        #7;
        forever #32 tx_input_clock = link_sel & ~tx_input_clock;
    end

    // reference path: fresh character after every loading edge
    always @(posedge clock) if (!link_sel) #1 {tx_ctrl, tx_data} = 10'($random(seed));

    // half rate: second character after the falling edge
    always @(negedge clock)
        if (!link_sel && half_rate) #1 {tx_ctrl, tx_data} = 10'($random(seed));

    // host path: each character held two link periods so none is lost
    always @(posedge tx_input_clock)
    begin
        hold_r = ~hold_r;
        if (hold_r) #1 {tx_ctrl, tx_data} = 10'($random(seed));
    end
endmodule : tph_host_model

// ---- bench/transceiver_parallel_host_interface_tb.sv ----
// testbench: host model drives transmit, bench drives pins and receive side
// assumes design latencies as handed over; model compared at every result
`timescale 1ns/1ps

module transceiver_parallel_host_interface_tb;
    logic clock = 1'b0, resetn = 1'b0, tx_input_clock, half_rate = 1'b0, align = 1'b0;
    logic [7:0] tx_data, rx_dec_byte = 8'h00, rx_byte, e_byte = 8'h00;
    logic [1:0] tx_ctrl, ck_sel = 2'h0, dec_sel = 2'h0;
    logic [3:0] mode_sel = 4'h0, ph, frz_ph, last_ph = 4'h0;
    logic [9:0] rx_raw = 10'h000, tx_word, tx_second, w0, ns;
    logic [2:0] rx_dec_status = 3'h0, rx_stat, e_stat = 3'h0;
    logic [8:0] onehot;
    logic comma = 1'b0, rv = 1'b0, valid, pair, inval, rx_clk, e_pulse = 1'b0;
    logic ref_chk = 1'b0, host_chk = 1'b0, frz = 1'b0, rx_go = 1'b0, hit;
    int seed = 60591, fail_count = 0, n_compared = 0, moves = 0, u, l;
    logic [9:0] q[$];

    always #10 clock = ~clock;

    tph_host_model u_host (.clock(clock), .link_sel(ck_sel != 2'h0), .half_rate(half_rate),
        .tx_input_clock(tx_input_clock), .tx_data(tx_data), .tx_ctrl(tx_ctrl));

    tph_host_port u_dut (.clock(clock), .resetn(resetn), .tx_input_clock(tx_input_clock),
        .tx_data(tx_data), .tx_ctrl(tx_ctrl), .tx_input_clock_select(ck_sel),
        .tx_operating_mode_select(mode_sel), .decoder_mode_select(dec_sel),
        .tx_ref_rate_select(half_rate), .tx_phase_align_reset(align), .rx_raw_char(rx_raw),
        .rx_dec_byte(rx_dec_byte), .rx_dec_status(rx_dec_status), .rx_comma_det(comma),
        .rx_char_valid(rv), .tx_word(tx_word), .tx_word_second(tx_second),
        .tx_word_valid(valid), .tx_word_pair(pair), .tx_phase_offset(ph),
        .tx_mode_onehot(onehot), .tx_config_invalid(inval), .rx_byte(rx_byte),
        .rx_char_status(rx_stat), .rx_char_clock_out(rx_clk));

    // compare one result against the model
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // wait some rising edges, then step just off the edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    // random receive characters, qualified only while rx_go
    always @(posedge clock)
    begin
        #1;
        {comma, rx_raw, rx_dec_byte, rx_dec_status} = 22'($random(seed));
        rv = rx_go & 1'($random(seed));
    end

    // model: sample pins and receive inputs at the rising edge
    always @(posedge clock)
    begin
        w0 = {tx_ctrl, tx_data};
        e_pulse = rv;
        if (rv && dec_sel == 2'h0) {e_byte, e_stat} = {rx_raw[9:2], comma, rx_raw[1:0]};
        else if (rv) {e_byte, e_stat} = {rx_dec_byte, rx_dec_status};
    end

    // model: host words captured at link edges, last three kept
    always @(posedge tx_input_clock)
    begin
        q.push_back({tx_ctrl, tx_data});
        if (q.size() > 3) void'(q.pop_front());
    end

    // compare settled outputs mid cycle
    always @(negedge clock)
    begin
        if (resetn)
        begin
            check(rx_byte, e_byte);
            check(rx_stat, e_stat);
            check(rx_clk, e_pulse);
        end
        if (ref_chk)
        begin
            check(tx_word, w0);
            check(valid, 1'b1);
            check(pair, half_rate);
            if (half_rate) check(tx_second, ns);
        end
        ns = {tx_ctrl, tx_data};
        if (host_chk && valid)
        begin
            hit = 1'b0;
            foreach (q[i]) if (q[i] === tx_word) hit = 1'b1;
            check(hit, 1'b1);
            check(pair, 1'b0);
            if (frz) check(ph, frz_ph);
            else if (ph !== last_ph) moves++;
            last_ph = ph;
        end
    end

    // watchdog
    initial
    begin
        #400000;
        fail_count++;
        tally_and_finish();
    end

    // main sequence
    initial
    begin
        step(6);
        resetn = 1'b1;
        // every mode pair, middle given as either floating pattern
        for (u = 0; u < 3; u++)
            for (l = 0; l < 3; l++)
            begin
                mode_sel[3:2] = (u == 0) ? 2'h0 : (u == 2) ? 2'h3 : 2'h1 + 2'($random(seed) & 1);
                mode_sel[1:0] = (l == 0) ? 2'h0 : (l == 2) ? 2'h3 : 2'h1 + 2'($random(seed) & 1);
                step(6);
                check(onehot, 9'h001 << (3 * u + l));
            end
        // invalid clock source with half-rate reference flagged; middle pattern 2'h1 tried at full rate only
        for (u = 0; u < 6; u++)
        begin
            ck_sel = (u < 2) ? 2'h0 : (u == 2) ? 2'h1 : (u == 3) ? 2'h2 : 2'h3;
            half_rate = u[0];
            step(6);
            check(inval, 1'(half_rate && ck_sel != 2'h0));
        end
        // reference path, full rate then half rate
        ck_sel = 2'h0;
        for (u = 0; u < 2; u++)
        begin
            half_rate = u[0];
            step(6);
            ref_chk = 1'b1;
            step(40);
            ref_chk = 1'b0;
        end
        // host path: phase tracked, then frozen; words in flight drained first
        half_rate = 1'b0;
        ck_sel = 2'h3;
        step(10);
        q.delete();
        step(4);
        host_chk = 1'b1;
        step(80);
        check(moves > 0, 1'b1);
        align = 1'b1;
        step(10);
        frz_ph = ph;
        frz = 1'b1;
        step(80);
        {host_chk, frz, ck_sel, align} = 5'h00;
        // receive in bypass, middle and high decoder modes
        for (u = 0; u < 3; u++)
        begin
            dec_sel = (u == 0) ? 2'h0 : (u == 1) ? 2'h2 : 2'h3;
            step(5);
            rx_go = 1'b1;
            step(60);
            rx_go = 1'b0;
            step(3);
        end
        step(4);
        tally_and_finish();
    end
endmodule : transceiver_parallel_host_interface_tb
